// file: hw/rarb_pkg.sv
// Package for the range and alarm register bank: offsets, field layout,
// reset values and range codes.
// Assumes a 32-bit APB slave with one aligned word per register.
package rarb_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RARB_OFS_RANGE     = 8'h14;
	localparam logic [7:0] RARB_OFS_ALARM     = 8'h20;
	localparam logic [7:0] RARB_OFS_HIGH_TH   = 8'h24;
	localparam logic [7:0] RARB_OFS_IRQ_STAT  = 8'h30;
	localparam logic [7:0] RARB_OFS_IRQ_MASK  = 8'h34;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RARB_RANGE_LSB    = 0;
	localparam int RARB_RANGE_W      = 4;
	localparam int RARB_REFOFF_BIT   = 6;
	localparam int RARB_ACT_SUP_LO   = 15;
	localparam int RARB_ACT_SUP_HI   = 14;
	localparam int RARB_ACT_IN_LO    = 11;
	localparam int RARB_ACT_IN_HI    = 10;
	localparam int RARB_TRP_SUP_LO   = 7;
	localparam int RARB_TRP_SUP_HI   = 6;
	localparam int RARB_TRP_IN_LO    = 5;
	localparam int RARB_TRP_IN_HI    = 4;
	localparam int RARB_SUMMARY_BIT  = 0;
	localparam int RARB_HYST_LSB     = 24;
	localparam int RARB_HYST_W       = 8;
	localparam int RARB_HYST_USED_W  = 2;
	localparam int RARB_LIMIT_LSB    = 0;
	localparam int RARB_LIMIT_W      = 16;
	localparam int RARB_LIMIT_CMP_LSB = 4;
	localparam int RARB_NUM_ALARMS   = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  RARB_RANGE_RST  = 4'h0;
	localparam logic        RARB_REFOFF_RST = 1'b0;
	localparam logic [7:0]  RARB_HYST_RST   = 8'h00;
	localparam logic [15:0] RARB_LIMIT_RST  = 16'hFFFF;
	localparam logic [3:0]  RARB_IRQ_RST    = 4'h0;

	// ----------------------------------------------------------------
	// Range codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		RARB_BI_3P0   = 4'h0,
		RARB_BI_2P5   = 4'h1,
		RARB_BI_1P5   = 4'h2,
		RARB_BI_1P25  = 4'h3,
		RARB_BI_0P625 = 4'h4,
		RARB_UNI_3P0  = 4'h8,
		RARB_UNI_2P5  = 4'h9,
		RARB_UNI_1P5  = 4'hA,
		RARB_UNI_1P25 = 4'hB
	} rarb_range_type;

	// Span one-hot: index 0..8 in code order above
	localparam int RARB_SPAN_N = 9;

endpackage

// file: hw/rarb_range_decode.sv
// Range-code decoder: turns the four-bit range code into a span select that is
// one-hot for legal codes and zero otherwise, a polarity flag and a legal flag.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
module rarb_range_decode
	import rarb_pkg::*;
(
	input  wire logic [3:0]             code,
	output logic      [RARB_SPAN_N-1:0] span_onehot,
	output logic                        unipolar,
	output logic                        legal
);

	always_comb
	begin
		span_onehot = '0;
		unipolar    = 1'b0;
		legal       = 1'b1;
		case (code)
			RARB_BI_3P0:   span_onehot[0] = 1'b1;
			RARB_BI_2P5:   span_onehot[1] = 1'b1;
			RARB_BI_1P5:   span_onehot[2] = 1'b1;
			RARB_BI_1P25:  span_onehot[3] = 1'b1;
			RARB_BI_0P625: span_onehot[4] = 1'b1;
			RARB_UNI_3P0:
			begin
				span_onehot[5] = 1'b1;
				unipolar       = 1'b1;
			end
			RARB_UNI_2P5:
			begin
				span_onehot[6] = 1'b1;
				unipolar       = 1'b1;
			end
			RARB_UNI_1P5:
			begin
				span_onehot[7] = 1'b1;
				unipolar       = 1'b1;
			end
			RARB_UNI_1P25:
			begin
				span_onehot[8] = 1'b1;
				unipolar       = 1'b1;
			end
			default: legal = 1'b0;
		endcase
	end

endmodule

// file: hw/rarb_bank.sv
// Range and alarm register bank of the converter control logic, APB slave.
// Assumes alarm condition inputs are asynchronous levels from analog
// comparators, and that sample codes come from the converter on pclk.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module rarb_bank
	import rarb_pkg::*;
#(
	parameter int SAMPLE_W = 16
)
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                supply_low_in,
	input  wire logic                supply_high_in,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] sample_code,
	output logic      [3:0]          range_code,
	output logic                     range_unipolar,
	output logic      [RARB_SPAN_N-1:0] range_span,
	output logic                     onchip_reference_off,
	output logic                     irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [31:0]            rdata;
		logic                   ready;
		logic                   slverr;
		logic [3:0]             range;
		logic                   refoff;
		logic                   unipolar;
		logic [RARB_SPAN_N-1:0] span;
		logic [7:0]             hyst;
		logic [15:0]            limit;
		logic [1:0]             sup_lo_sync;
		logic [1:0]             sup_hi_sync;
		logic                   act_sup_lo;
		logic                   act_sup_hi;
		logic                   act_in_lo;
		logic                   act_in_hi;
		logic [3:0]             trip;
		logic [3:0]             trip_prev;
		logic [3:0]             irq_stat;
		logic [3:0]             irq_mask;
		logic                   irq;
	} rarb_state_type;

	rarb_state_type st_q;
	rarb_state_type st_d;

	logic [RARB_SPAN_N-1:0] dec_span;
	logic                   dec_unipolar;
	logic                   dec_legal;

	rarb_range_decode u_decode
	(
		.code        (st_q.range),
		.span_onehot (dec_span),
		.unipolar    (dec_unipolar),
		.legal       (dec_legal)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic        setup;
	logic        wr;
	logic        rd;
	logic        rd_alarm;
	logic [31:0] alarm_word;
	logic [31:0] range_word;
	logic [31:0] high_word;
	logic [11:0] upper_cmp;
	logic [11:0] sample_top;
	logic [11:0] release_lvl;
	logic [3:0]  trip_set;
	logic [3:0]  trip_rise;

	always_comb
	begin
		st_d        = st_q;
		setup       = psel && !penable;
		wr          = setup && pwrite;
		rd          = setup && !pwrite;
		rd_alarm    = rd && (paddr == RARB_OFS_ALARM);
		upper_cmp   = st_q.limit[RARB_LIMIT_W-1:RARB_LIMIT_CMP_LSB];
		sample_top  = sample_code[SAMPLE_W-1 -: 12];
		// Hysteresis pulls the release point below the limit by up to 3 codes
		release_lvl = upper_cmp - 12'(st_q.hyst[RARB_HYST_W-1 -: RARB_HYST_USED_W]);
		alarm_word  = '0;
		range_word  = '0;
		high_word   = '0;
		trip_set    = '0;
		trip_rise   = '0;

		// Supply comparators are asynchronous: two flops before use
		st_d.sup_lo_sync = {st_q.sup_lo_sync[0], supply_low_in};
		st_d.sup_hi_sync = {st_q.sup_hi_sync[0], supply_high_in};
		st_d.act_sup_lo  = st_q.sup_lo_sync[1];
		st_d.act_sup_hi  = st_q.sup_hi_sync[1];

		// Input alarm: above limit sets, dropping to or below limit minus hysteresis clears
		if (sample_valid)
		begin
			if (sample_top > upper_cmp)
				st_d.act_in_hi = 1'b1;
			else if (sample_top <= release_lvl)
				st_d.act_in_hi = 1'b0;
			// Low threshold lives elsewhere; low flag stays clear here
			st_d.act_in_lo = 1'b0;
		end

		trip_set = {st_q.act_sup_lo, st_q.act_sup_hi, st_q.act_in_lo, st_q.act_in_hi};

		// Latched flags: a read clears, but a live condition keeps them set
		if (rd_alarm)
			st_d.trip = trip_set;
		else
			st_d.trip = st_q.trip | trip_set;

		alarm_word[RARB_ACT_SUP_LO]  = st_q.act_sup_lo;
		alarm_word[RARB_ACT_SUP_HI]  = st_q.act_sup_hi;
		alarm_word[RARB_ACT_IN_LO]   = st_q.act_in_lo;
		alarm_word[RARB_ACT_IN_HI]   = st_q.act_in_hi;
		alarm_word[RARB_TRP_SUP_LO]  = st_q.trip[3];
		alarm_word[RARB_TRP_SUP_HI]  = st_q.trip[2];
		alarm_word[RARB_TRP_IN_LO]   = st_q.trip[1];
		alarm_word[RARB_TRP_IN_HI]   = st_q.trip[0];
		alarm_word[RARB_SUMMARY_BIT] = |st_q.trip;

		range_word[RARB_RANGE_LSB +: RARB_RANGE_W] = st_q.range;
		range_word[RARB_REFOFF_BIT]                = st_q.refoff;
		high_word[RARB_HYST_LSB +: RARB_HYST_W]    = st_q.hyst;
		high_word[RARB_LIMIT_LSB +: RARB_LIMIT_W]  = st_q.limit;

		// Interrupt status: rising edge of each latched flag; set wins over clear
		st_d.trip_prev = st_d.trip;
		trip_rise      = st_d.trip & ~st_q.trip_prev;
		if (wr && paddr == RARB_OFS_IRQ_STAT)
			st_d.irq_stat = (st_q.irq_stat & ~pwdata[3:0]) | trip_rise;
		else
			st_d.irq_stat = st_q.irq_stat | trip_rise;

		// APB: answer in the access cycle after setup, zero wait states
		st_d.ready  = setup;
		st_d.slverr = 1'b0;
		st_d.rdata  = '0;
		if (setup)
		begin
			if (paddr == RARB_OFS_RANGE)
			begin
				st_d.rdata = range_word;
				if (pwrite)
				begin
					st_d.range  = pwdata[RARB_RANGE_LSB +: RARB_RANGE_W];
					st_d.refoff = pwdata[RARB_REFOFF_BIT];
				end
			end
			else if (paddr == RARB_OFS_ALARM)
			begin
				st_d.rdata = alarm_word;
			end
			else if (paddr == RARB_OFS_HIGH_TH)
			begin
				st_d.rdata = high_word;
				if (pwrite)
				begin
					st_d.hyst  = pwdata[RARB_HYST_LSB +: RARB_HYST_W];
					st_d.limit = pwdata[RARB_LIMIT_LSB +: RARB_LIMIT_W];
				end
			end
			else if (paddr == RARB_OFS_IRQ_STAT)
			begin
				st_d.rdata[3:0] = st_q.irq_stat;
			end
			else if (paddr == RARB_OFS_IRQ_MASK)
			begin
				st_d.rdata[3:0] = st_q.irq_mask;
				if (pwrite)
					st_d.irq_mask = pwdata[3:0];
			end
			else
			begin
				st_d.slverr = 1'b1;
			end
		end

		// Illegal codes keep the last legal span and polarity so the front end never floats
		if (dec_legal)
		begin
			st_d.span     = dec_span;
			st_d.unipolar = dec_unipolar;
		end
		st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q          <= '0;
			st_q.range    <= RARB_RANGE_RST;
			st_q.refoff   <= RARB_REFOFF_RST;
			st_q.span     <= RARB_SPAN_N'(1);
			st_q.hyst     <= RARB_HYST_RST;
			st_q.limit    <= RARB_LIMIT_RST;
			st_q.irq_stat <= RARB_IRQ_RST;
			st_q.irq_mask <= RARB_IRQ_RST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign prdata               = st_q.rdata;
	assign pready               = st_q.ready;
	assign pslverr              = st_q.slverr;
	assign range_code           = st_q.range;
	assign range_unipolar       = st_q.unipolar;
	assign range_span           = st_q.span;
	assign onchip_reference_off = st_q.refoff;
	assign irq                  = st_q.irq;

endmodule

// file: tb/rarb_monitor.sv
// Checker for the range and alarm register bank, bound to the bank.
// Assumes APB requests come as setup then access.
`timescale 1ns/1ps
module rarb_monitor
	import rarb_pkg::*;
#(
	parameter int SAMPLE_W = 16
)
(
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   supply_low_in,
	input wire logic                   supply_high_in,
	input wire logic                   sample_valid,
	input wire logic [SAMPLE_W-1:0]    sample_code,
	input wire logic [3:0]             range_code,
	input wire logic                   range_unipolar,
	input wire logic [RARB_SPAN_N-1:0] range_span,
	input wire logic                   onchip_reference_off,
	input wire logic                   irq
);
	logic mapped;
	assign mapped = paddr inside {RARB_OFS_RANGE, RARB_OFS_ALARM, RARB_OFS_HIGH_TH, RARB_OFS_IRQ_STAT, RARB_OFS_IRQ_MASK};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence read_s(logic [7:0] a);
		setup_s ##0 (!pwrite && paddr == a);
	endsequence
	// Illegal codes are left out: the bank keeps the last legal span and polarity for them
	sequence range_wr_s;
		setup_s ##0 (pwrite && paddr == RARB_OFS_RANGE && pwdata[3:0] inside {[4'h0:4'h4], [4'h8:4'hB]});
	endsequence
	property range_out_p;
		range_wr_s |-> ##2 (range_code == $past(pwdata[3:0], 2) && range_unipolar == $past(pwdata[3], 2)
			&& onchip_reference_off == $past(pwdata[6], 2));
	endproperty
	answer_once_a: assert property (setup_s |=> pready ##1 !pready)
		else $error("answer not one cycle after setup");
	unmapped_error_a: assert property (setup_s ##0 !mapped |=> pready && pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr)
		else $error("mapped access refused");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access cycle");
	alarm_read_a: assert property (read_s(RARB_OFS_ALARM) |=> (prdata & 32'hFFFF330E) == 32'h0
		&& prdata[0] == |prdata[7:4])
		else $error("alarm status word malformed");
	range_read_a: assert property (read_s(RARB_OFS_RANGE) |=> (prdata & 32'hFFFFFFB0) == 32'h0)
		else $error("range reserved bits not zero");
	limit_read_a: assert property (read_s(RARB_OFS_HIGH_TH) |=> prdata[23:16] == 8'h00)
		else $error("threshold reserved bits not zero");
	range_ports_a: assert property (range_out_p)
		else $error("range outputs do not follow write");
	span_onehot_a: assert property ($onehot(range_span))
		else $error("span select not one-hot");
endmodule
bind rarb_bank rarb_monitor #(.SAMPLE_W(SAMPLE_W)) mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .supply_low_in, .supply_high_in, .sample_valid, .sample_code, .range_code,
	.range_unipolar, .range_span, .onchip_reference_off, .irq);

// file: tb/testbench.sv
// Self-checking bench for the range and alarm register bank.
// Assumes the bank answers an APB access within 50 cycles.
`timescale 1ns/1ps
module testbench;
	import rarb_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic x;} rarb_row_type;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        sup_lo = 1'b0, sup_hi = 1'b0, sample_valid = 1'b0, pready, pslverr, uni, ref_off, irq, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [15:0] sample_code = 16'h0;
	logic [3:0]  rcode;
	logic [8:0]  span;
	int          failures = 0, n_compared = 0;
	logic [3:0]  codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};
	logic [7:0]  ra[5] = '{8'h14, 8'h20, 8'h24, 8'h30, 8'h34};
	logic [31:0] re[5] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0};
	logic [15:0] smp[4] = '{16'h0100, 16'h0110, 16'h0100, 16'h00F0};
	logic [31:0] sx[4] = '{32'h0, 32'h00000411, 32'h00000411, 32'h00000011};
	rarb_row_type rows[6] = '{'{8'h24, 32'hC0FFFFF0, 32'hC000FFF0, 1'b0}, '{8'h24, 32'h40000100, 32'h40000100, 1'b0},
		'{8'h20, 32'hFFFFFFFF, 32'h0, 1'b0}, '{8'h34, 32'h0000000F, 32'h0000000F, 1'b0},
		'{8'h30, 32'h0000000F, 32'h0, 1'b0}, '{8'h40, 32'h12345678, 32'h0, 1'b1}};
	always #5 pclk = ~pclk;
	rarb_bank #(.SAMPLE_W(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .supply_low_in(sup_lo), .supply_high_in(sup_hi), .sample_valid, .sample_code, .range_code(rcode),
		.range_unipolar(uni), .range_span(span), .onchip_reference_off(ref_off), .irq);
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Request held until pready is seen at a rising edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			failures++;
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic samp(logic [15:0] c);
		@(posedge pclk);
		sample_valid <= 1'b1;
		sample_code <= c;
		@(posedge pclk);
		sample_valid <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic irq_is(logic v);
		repeat (3) @(posedge pclk);
		check("irq", {31'h0, irq}, {31'h0, v});
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		close_out();
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 32'h0);
			check("error", {31'h0, err}, {31'h0, rows[i].x});
			if (!rows[i].x)
				check("readback", r, rows[i].e);
		end
		$display("table done");
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b1, 8'h14, {24'hFFFFFF, 1'b1, i[0], 2'h3, codes[i]});
			apb(1'b0, 8'h14, 32'h0);
			check("range", r, {25'h0, i[0], 2'h0, codes[i]});
			check("span", {23'h0, span}, 32'h1 << i);
			check("ports", {26'h0, rcode, uni, ref_off}, {26'h0, codes[i], i > 4, i[0]});
		end
		// Undefined code: stored and read back, span and polarity keep the last legal choice
		apb(1'b1, 8'h14, 32'h00000005);
		apb(1'b0, 8'h14, 32'h0);
		check("range", r, 32'h00000005);
		check("held span", {18'h0, rcode, uni, span}, {18'h0, 4'h5, 1'b1, 9'h100});
		$display("range done");
		// Second reset in mid-run: everything must return to reset state
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		check("reset ports", {16'h0, span, uni, ref_off, irq, rcode}, {16'h0, 9'h001, 7'h0});
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			check("reset value", r, re[i]);
		end
		$display("reset done");
		apb(1'b1, 8'h34, 32'h0000000B);
		sup_lo <= 1'b1;
		sup_hi <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, 8'h20, 32'h0);
		check("alarm", r, 32'h0000C0C1);
		sup_lo <= 1'b0;
		sup_hi <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, 8'h20, 32'h0);
		check("alarm", r, 32'h000000C1);
		apb(1'b0, 8'h20, 32'h0);
		check("alarm", r, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		check("irq status", r, 32'h0000000C);
		irq_is(1'b1);
		apb(1'b1, 8'h30, 32'h00000008);
		irq_is(1'b0);
		apb(1'b1, 8'h34, 32'h0000000F);
		irq_is(1'b1);
		apb(1'b1, 8'h30, 32'h00000004);
		irq_is(1'b0);
		$display("supply done");
		apb(1'b1, 8'h24, 32'h40000100);
		for (int i = 0; i < 4; i++)
		begin
			samp(smp[i]);
			apb(1'b0, 8'h20, 32'h0);
			check("input alarm", r, sx[i]);
		end
		apb(1'b0, 8'h20, 32'h0);
		check("input alarm", r, 32'h0);
		irq_is(1'b1);
		apb(1'b1, 8'h30, 32'h00000001);
		irq_is(1'b0);
		$display("input done");
		close_out();
	end
endmodule
